/* pkg/pmls_pkg.sv */
/*
 * pmls_pkg: offsets, field positions, reset values and carrier structs of the
 * link status and power management register bank.
 * Assumes a single system clock and a 32-bit word register port.
 */
package pmls_pkg;
    localparam logic [7:0] PMLS_OFF_RX_COUNT = 8'h00;
    localparam logic [7:0] PMLS_OFF_EARLY_RX = 8'h04;
    localparam logic [7:0] PMLS_OFF_FLOW_CTL = 8'h08;
    localparam logic [7:0] PMLS_OFF_WAKE = 8'h0C;
    localparam logic [7:0] PMLS_OFF_GEN = 8'h10;

    // wake byte sits in bits 31:24 of its word
    localparam int PMLS_WAKE_LSB = 24;
    localparam int PMLS_WK_PME = 0;
    localparam int PMLS_WK_PKT = 5;
    localparam int PMLS_WK_NOSUP = 6;
    localparam int PMLS_WK_LINK = 7;
    localparam logic [7:0] PMLS_WAKE_RST = 8'h00;
    localparam logic [7:0] PMLS_WAKE_IMPL = 8'hA1;

    localparam int PMLS_FC_CMD_LSB = 16;
    localparam logic [1:0] PMLS_FC_OFF = 2'h0;
    localparam logic [1:0] PMLS_FC_ON = 2'h1;
    localparam logic [1:0] PMLS_FC_PAUSE = 2'h2;
    localparam logic [11:0] PMLS_FC_THR_RST = 12'h000;
    localparam logic [15:0] PMLS_ER_THR_RST = 16'h0000;

    localparam int PMLS_GC_CLKRUN_DIS = 0;
    localparam int PMLS_GC_DEEP_PD = 1;
    localparam int PMLS_GS_LSB = 8;
    localparam logic [1:0] PMLS_GCTL_RST = 2'h0;
    localparam logic [1:0] PMLS_D2 = 2'h2;
    localparam logic [1:0] PMLS_D3 = 2'h3;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmls_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } pmls_rsp_t;

    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
    } pmls_phy_t;
endpackage

/* verilog/pmls_csr.sv */
/*
 * pmls_csr: host registers for receive byte count, early receive trigger,
 * flow control, wake events and general control/status.
 * Assumes host accesses arrive as one-cycle requests synchronous to clk_sys,
 * and that the command block turns the early receive pulse into its status
 * flag and interrupt.
 */
`timescale 1ns/1ps
module pmls_csr
    import pmls_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic alternate_reset_pin_n,
    input wire pmls_req_t host_req,
    output pmls_rsp_t host_rsp_r,
    input wire logic rx_dma_valid,
    input wire logic [11:0] rx_dma_nbytes,
    input wire logic rx_frame_start,
    input wire logic [15:0] rx_frame_len,
    input wire logic [11:0] rx_fifo_free,
    input wire pmls_phy_t phy,
    input wire logic pkt_interesting,
    input wire logic wake_event,
    input wire logic pme_enable,
    input wire logic pmcsr_status_clr,
    input wire logic [1:0] power_state,
    output logic early_rx_flag_r,
    output logic [1:0] fc_cmd_r,
    output logic fc_pause_req_r,
    output logic pme_status_r,
    output logic pme_assert_r,
    output logic deep_pd_ok_r,
    output logic pci_clk_req_r
);
    typedef struct packed {
        pmls_rsp_t rsp;
        logic [31:0] rx_count;
        logic [15:0] er_thr;
        logic er_armed;
        logic er_pulse;
        logic [11:0] fc_thr;
        logic [1:0] fc_cmd;
        logic fc_pause;
        logic [1:0] gctl;
        pmls_phy_t gsts;
        logic link_prev;
        logic link_primed;
        logic pme_out;
        logic deep_pd;
        logic clk_req;
    } pmls_state_t;

    pmls_state_t st_r;
    pmls_state_t st_nxt;
    logic [7:0] wake_r;
    logic [7:0] wake_nxt;
    logic [7:0] wake_clr;
    logic link_chg;
    logic wake_any;
    logic wr_hit;

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_wr(input pmls_req_t rq, input logic [7:0] off);
        return rq.valid && rq.write && (rq.addr == off);
    endfunction

    function automatic logic is_rd(input pmls_req_t rq, input logic [7:0] off);
        return rq.valid && !rq.write && (rq.addr == off);
    endfunction

    // first edge after system reset only primes the tracker, so rstn cannot fake a link change;
    // a change while rstn is low goes unrecorded
    assign link_chg = st_r.link_primed && (phy.link_up ^ st_r.link_prev);
    assign wake_any = link_chg | pkt_interesting | wake_event;
    assign wr_hit = is_wr(host_req, PMLS_OFF_WAKE) && host_req.be[3];
    // only ones clear; a zero leaves the bit alone
    assign wake_clr = wr_hit ? host_req.wdata[31:24] : 8'h00;

    // set beats clear in the same cycle so no wake event is lost
    always_comb begin
        wake_nxt = wake_r & ~wake_clr & PMLS_WAKE_IMPL;
        wake_nxt[PMLS_WK_LINK] = wake_nxt[PMLS_WK_LINK] | link_chg;
        wake_nxt[PMLS_WK_PKT] = wake_nxt[PMLS_WK_PKT] | pkt_interesting;
        // PMCSR status clear from config space also drops the mirror
        wake_nxt[PMLS_WK_PME] = (wake_nxt[PMLS_WK_PME] & ~pmcsr_status_clr) | wake_any;
    end

    // own reset domain: system reset must not wipe pending wake causes
    always_ff @(posedge clk_sys or negedge alternate_reset_pin_n) begin
        if (!alternate_reset_pin_n) begin
            wake_r <= PMLS_WAKE_RST;
        end else begin
            wake_r <= wake_nxt;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.valid = host_req.valid && !host_req.write;
        st_nxt.rsp.data = 32'h0000_0000;
        if (host_req.valid && !host_req.write) begin
            unique case (host_req.addr)
                PMLS_OFF_RX_COUNT: st_nxt.rsp.data = st_r.rx_count;
                PMLS_OFF_EARLY_RX: st_nxt.rsp.data = {16'h0000, st_r.er_thr};
                PMLS_OFF_FLOW_CTL: st_nxt.rsp.data = {14'h0000, st_r.fc_cmd, 4'h0, st_r.fc_thr};
                PMLS_OFF_WAKE: st_nxt.rsp.data = {wake_r, 24'h00_0000};
                PMLS_OFF_GEN: st_nxt.rsp.data = {16'h0000, 5'h00, st_r.gsts.full_duplex,
                                                 st_r.gsts.speed_100, st_r.gsts.link_up,
                                                 6'h00, st_r.gctl};
                default: st_nxt.rsp.data = 32'h0000_0000;
            endcase
        end
        if (rx_dma_valid) begin
            st_nxt.rx_count = st_r.rx_count + {20'h0_0000, rx_dma_nbytes};
        end
        if (is_wr(host_req, PMLS_OFF_EARLY_RX)) begin
            st_nxt.er_thr = 16'(merge_be({16'h0000, st_r.er_thr}, host_req.wdata, host_req.be));
        end
        if (is_wr(host_req, PMLS_OFF_FLOW_CTL)) begin
            st_nxt.fc_thr = 12'(merge_be({20'h0_0000, st_r.fc_thr}, host_req.wdata, host_req.be));
            if (host_req.be[2]) begin
                st_nxt.fc_cmd = host_req.wdata[PMLS_FC_CMD_LSB +: 2];
            end
        end
        if (is_wr(host_req, PMLS_OFF_GEN) && host_req.be[0]) begin
            st_nxt.gctl = host_req.wdata[1:0];
        end
        // one pulse per frame; zero threshold disables the trigger
        st_nxt.er_pulse = 1'b0;
        if (rx_frame_start) begin
            st_nxt.er_armed = 1'b1;
        end else if (st_r.er_armed && st_r.er_thr != 16'h0000 && rx_frame_len >= st_r.er_thr) begin
            st_nxt.er_pulse = 1'b1;
            st_nxt.er_armed = 1'b0;
        end
        unique case (st_r.fc_cmd)
            PMLS_FC_PAUSE: st_nxt.fc_pause = 1'b1;
            PMLS_FC_ON: st_nxt.fc_pause = rx_fifo_free < st_r.fc_thr;
            default: st_nxt.fc_pause = 1'b0;
        endcase
        st_nxt.gsts = phy;
        st_nxt.link_prev = phy.link_up;
        st_nxt.link_primed = 1'b1;
        // no PME while the wake byte is held in its own reset
        st_nxt.pme_out = wake_nxt[PMLS_WK_PME] & pme_enable & alternate_reset_pin_n;
        // link integrity is lost once powered down; software must keep this off point to point
        st_nxt.deep_pd = st_r.gctl[PMLS_GC_DEEP_PD] && !phy.link_up
                         && (power_state == PMLS_D2 || power_state == PMLS_D3);
        st_nxt.clk_req = st_r.gctl[PMLS_GC_CLKRUN_DIS];
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{rsp: '{valid: 1'b0, data: 32'h0000_0000}, rx_count: 32'h0000_0000,
                      er_thr: PMLS_ER_THR_RST, er_armed: 1'b0, er_pulse: 1'b0,
                      fc_thr: PMLS_FC_THR_RST, fc_cmd: PMLS_FC_OFF, fc_pause: 1'b0,
                      gctl: PMLS_GCTL_RST, gsts: '{link_up: 1'b0, speed_100: 1'b0, full_duplex: 1'b0},
                      link_prev: 1'b0, link_primed: 1'b0, pme_out: 1'b0, deep_pd: 1'b0, clk_req: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign host_rsp_r = st_r.rsp;
    assign early_rx_flag_r = st_r.er_pulse;
    assign fc_cmd_r = st_r.fc_cmd;
    assign fc_pause_req_r = st_r.fc_pause;
    assign pme_status_r = wake_r[PMLS_WK_PME];
    assign pme_assert_r = st_r.pme_out;
    assign deep_pd_ok_r = st_r.deep_pd;
    assign pci_clk_req_r = st_r.clk_req;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn || !alternate_reset_pin_n);

    a_count_adds: assert property (rx_dma_valid |=> st_r.rx_count == $past(st_r.rx_count)
                                   + {20'h0_0000, $past(rx_dma_nbytes)})
        else $error("receive byte count did not advance");
    a_early_once: assert property (early_rx_flag_r |=> !early_rx_flag_r)
        else $error("early receive pulse longer than one cycle");
    a_early_cause: assert property (st_r.er_armed && !rx_frame_start && st_r.er_thr != 16'h0000
                                    && rx_frame_len >= st_r.er_thr |=> early_rx_flag_r)
        else $error("early receive not raised at threshold");
    a_fc_cmd_wr: assert property (is_wr(host_req, PMLS_OFF_FLOW_CTL) && host_req.be[2]
                                  |=> fc_cmd_r == $past(host_req.wdata[17:16]))
        else $error("flow command not stored");
    a_fc_thr_use: assert property (fc_cmd_r == PMLS_FC_ON && !$changed(fc_cmd_r)
                                   |-> fc_pause_req_r == ($past(rx_fifo_free) < $past(st_r.fc_thr)))
        else $error("flow pause disagrees with threshold");
    a_wake_read: assert property (host_req.valid && !host_req.write && host_req.addr == PMLS_OFF_WAKE
                                  |=> host_rsp_r.valid && host_rsp_r.data[31:24] == $past(wake_r))
        else $error("wake register read wrong");
    a_link_sets: assert property (link_chg |=> wake_r[PMLS_WK_LINK] && pme_status_r)
        else $error("link change not recorded");
    a_nosup_zero: assert property (wake_r[PMLS_WK_NOSUP] == 1'b0)
        else $error("unsupported wake bit set");
    a_pkt_sets: assert property (pkt_interesting |=> wake_r[PMLS_WK_PKT] ##0 pme_status_r)
        else $error("interesting packet not recorded");
    a_pme_clear: assert property (wr_hit && host_req.wdata[24] && !wake_any
                                  |=> !pme_status_r && !pme_assert_r)
        else $error("pme not cleared by write one");
    a_zero_keeps: assert property (wr_hit && !host_req.wdata[31] && wake_r[PMLS_WK_LINK]
                                   |=> wake_r[PMLS_WK_LINK])
        else $error("writing zero cleared a wake bit");
    a_deep_pd: assert property (deep_pd_ok_r |-> $past(st_r.gctl[PMLS_GC_DEEP_PD]) && !$past(phy.link_up))
        else $error("deep power-down without enable or with link");
    a_clk_req: assert property (st_r.gctl[PMLS_GC_CLKRUN_DIS] && !is_wr(host_req, PMLS_OFF_GEN)
                                |=> pci_clk_req_r [*2])
        else $error("clock request dropped while clockrun disabled");
    a_status_rd: assert property (host_req.valid && !host_req.write && host_req.addr == PMLS_OFF_GEN
                                  |=> host_rsp_r.data[15:8] == {5'h00, $past(st_r.gsts.full_duplex),
                                  $past(st_r.gsts.speed_100), $past(st_r.gsts.link_up)})
        else $error("general status read wrong");

    a_count_hold: assert property (
        !rx_dma_valid
        |=> st_r.rx_count == $past(st_r.rx_count))
        else $error("receive byte count moved without a transfer");
    a_count_read: assert property (
        is_rd(host_req, PMLS_OFF_RX_COUNT)
        |=> host_rsp_r.data == $past(st_r.rx_count))
        else $error("receive byte count read wrong");
    a_early_disarm: assert property (
        early_rx_flag_r
        |-> !st_r.er_armed)
        else $error("early receive still armed after its pulse");
    a_early_off: assert property (
        st_r.er_thr == 16'h0000
        |=> !early_rx_flag_r)
        else $error("early receive fired with zero threshold");
    a_early_rearm: assert property (
        rx_frame_start
        |=> st_r.er_armed)
        else $error("frame start did not rearm early receive");
    a_fc_pause_cmd: assert property (
        fc_cmd_r == PMLS_FC_PAUSE && !$changed(fc_cmd_r)
        |-> fc_pause_req_r)
        else $error("pause command without pause request");
    a_fc_off: assert property (
        fc_cmd_r != PMLS_FC_ON && fc_cmd_r != PMLS_FC_PAUSE && !$changed(fc_cmd_r)
        |-> !fc_pause_req_r)
        else $error("pause request while flow control off");
    a_fc_thr_wr: assert property (
        is_wr(host_req, PMLS_OFF_FLOW_CTL) && host_req.be[0]
        |=> st_r.fc_thr[7:0] == $past(host_req.wdata[7:0]))
        else $error("flow threshold not stored");
    a_link_w1c: assert property (
        wr_hit && host_req.wdata[31] && !link_chg
        |=> !wake_r[PMLS_WK_LINK])
        else $error("link change bit not cleared by write one");
    a_pkt_w1c: assert property (
        wr_hit && host_req.wdata[29] && !pkt_interesting
        |=> !wake_r[PMLS_WK_PKT])
        else $error("packet bit not cleared by write one");
    a_wake_rsvd: assert property (
        is_rd(host_req, PMLS_OFF_WAKE)
        |=> host_rsp_r.data[30] == 1'b0 && host_rsp_r.data[28:25] == 4'h0)
        else $error("unsupported wake bits read nonzero");
    a_pme_any: assert property (
        wake_any
        |=> pme_status_r)
        else $error("wake cause did not set pme status");
    a_pme_follow: assert property (
        pme_assert_r
        |-> pme_status_r)
        else $error("pme asserted without pme status");
    a_pme_gate: assert property (
        !pme_enable
        |=> !pme_assert_r)
        else $error("pme asserted while disabled");
    a_pmcsr_clr: assert property (
        pmcsr_status_clr && !wake_any
        |=> !pme_status_r)
        else $error("config space clear did not drop pme status");
    a_wake_kept: assert property (@(posedge clk_sys) disable iff (!alternate_reset_pin_n)
        !rstn && !pkt_interesting && !wake_event && !wr_hit && !pmcsr_status_clr
        |=> wake_r == $past(wake_r))
        else $error("system reset changed the wake register");
    a_gctl_wr: assert property (
        is_wr(host_req, PMLS_OFF_GEN) && host_req.be[0]
        |=> st_r.gctl == $past(host_req.wdata[1:0]))
        else $error("general control not stored");
    a_gctl_keep: assert property (
        !(is_wr(host_req, PMLS_OFF_GEN) && host_req.be[0])
        |=> st_r.gctl == $past(st_r.gctl))
        else $error("general control changed without a write");
    a_deep_pd_on: assert property (
        st_r.gctl[PMLS_GC_DEEP_PD] && !phy.link_up && power_state == PMLS_D3
        |=> deep_pd_ok_r)
        else $error("deep power-down not allowed in low power state");
    a_deep_pd_state: assert property (
        deep_pd_ok_r
        |-> $past(power_state) == PMLS_D2 || $past(power_state) == PMLS_D3)
        else $error("deep power-down outside low power states");
    a_clk_req_off: assert property (
        !st_r.gctl[PMLS_GC_CLKRUN_DIS]
        |=> !pci_clk_req_r)
        else $error("clock request forced while clockrun enabled");
    a_status_track: assert property (
        1'b1
        |=> st_r.gsts == $past(phy))
        else $error("general status does not follow the phy");
    a_status_rsvd: assert property (
        is_rd(host_req, PMLS_OFF_GEN)
        |=> host_rsp_r.data[15:11] == 5'h00 && host_rsp_r.data[7:2] == 6'h00)
        else $error("reserved general bits read nonzero");
    a_rsp_idle: assert property (
        !(host_req.valid && !host_req.write)
        |=> !host_rsp_r.valid && host_rsp_r.data == 32'h0000_0000)
        else $error("read response without a read");

    c_early_fire: cover property (rx_frame_start ##[1:20] early_rx_flag_r);
    c_wake_clear: cover property (pme_status_r ##1 wr_hit ##1 !pme_status_r);
    c_set_clear_same: cover property (wr_hit && host_req.wdata[31] && link_chg);
    c_deep_pd: cover property (deep_pd_ok_r);
    c_fc_pause: cover property (fc_cmd_r == PMLS_FC_ON && fc_pause_req_r);
endmodule

/* test/test_pmls_csr.sv */
/*
 * test_pmls_csr: self-checking bench for the link status register bank.
 * Assumes pmls_pkg offsets and one-cycle host requests, answered one cycle later.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module test_pmls_csr import pmls_pkg::*;;
    logic clk_sys = 0;
    logic rstn = 0;
    logic alt_n = 0;
    pmls_req_t req = '0;
    pmls_rsp_t rsp;
    logic dma_v = 0;
    logic [11:0] dma_n = '0;
    logic fstart = 0;
    logic [15:0] flen = '0;
    logic [11:0] ffree = 12'hFFF;
    pmls_phy_t phy = '0;
    logic pkt = 0;
    logic wev = 0;
    logic pme_en = 0;
    logic pclr = 0;
    logic [1:0] pstate = '0;
    logic erf, fc_pause, pme_st, pme_as, dpd, clkreq;
    logic [1:0] fc_cmd;
    logic [1:0] cmds [3] = '{PMLS_FC_OFF, PMLS_FC_ON, PMLS_FC_PAUSE};
    int err_count = 0;
    int num_checks = 0;

    pmls_csr pmls_csr_inst (.clk_sys(clk_sys), .rstn(rstn), .alternate_reset_pin_n(alt_n),
        .host_req(req), .host_rsp_r(rsp), .rx_dma_valid(dma_v), .rx_dma_nbytes(dma_n),
        .rx_frame_start(fstart), .rx_frame_len(flen), .rx_fifo_free(ffree), .phy(phy),
        .pkt_interesting(pkt), .wake_event(wev), .pme_enable(pme_en), .pmcsr_status_clr(pclr),
        .power_state(pstate), .early_rx_flag_r(erf), .fc_cmd_r(fc_cmd), .fc_pause_req_r(fc_pause),
        .pme_status_r(pme_st), .pme_assert_r(pme_as), .deep_pd_ok_r(dpd), .pci_clk_req_r(clkreq));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // extra cycle after the take edge so the write has landed
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        req <= '{1'b1, 1'b1, a, be, d};
        cyc(1);
        req <= '0;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        req <= '{1'b1, 1'b0, a, 4'h0, 32'h0};
        cyc(1);
        // response stands one cycle only
        `CHK(rsp.valid, 1'b1)
        `CHK(rsp.data, e)
        req <= '0;
        cyc(1);
        `CHK(rsp.valid, 1'b0)
    endtask

    task results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #50000;
        err_count++;
        results;
    end

    initial begin
        cyc(4);
        rstn = 1;
        alt_n = 1;
        cyc(1);
        rd(PMLS_OFF_GEN, 32'h0);
        rd(PMLS_OFF_WAKE, 32'h0);
        rd(8'h20, 32'h0);
        dma_n = 12'h100;
        dma_v = 1;
        cyc(1);
        dma_n = 12'hFFF;
        cyc(1);
        dma_v = 0;
        cyc(1);
        rd(PMLS_OFF_RX_COUNT, 32'h10FF);
        wr(PMLS_OFF_EARLY_RX, 4'h3, 32'h40);
        fstart = 1;
        cyc(1);
        fstart = 0;
        flen = 16'h40;
        cyc(1);
        `CHK(erf, 1'b1)
        cyc(1);
        `CHK(erf, 1'b0)
        // free below threshold, so only off leaves pause low
        ffree = 12'h0FF;
        foreach (cmds[i]) begin
            wr(PMLS_OFF_FLOW_CTL, 4'h7, {14'h0, cmds[i], 4'h0, 12'h100});
            cyc(1);
            `CHK(fc_cmd, cmds[i])
            `CHK(fc_pause, cmds[i] != PMLS_FC_OFF)
        end
        wr(PMLS_OFF_FLOW_CTL, 4'h4, {14'h0, PMLS_FC_ON, 16'h0});
        ffree = 12'h100;
        cyc(2);
        `CHK(fc_pause, 1'b0)
        pme_en = 1;
        phy.link_up = 1;
        cyc(2);
        `CHK(pme_as, 1'b1)
        rd(PMLS_OFF_WAKE, 32'h81000000);
        wr(PMLS_OFF_WAKE, 4'h8, 32'h0);
        rd(PMLS_OFF_WAKE, 32'h81000000);
        wr(PMLS_OFF_WAKE, 4'h8, 32'h01000000);
        `CHK(pme_st, 1'b0)
        `CHK(pme_as, 1'b0)
        rd(PMLS_OFF_WAKE, 32'h80000000);
        wr(PMLS_OFF_WAKE, 4'h8, 32'hFF000000);
        rd(PMLS_OFF_WAKE, 32'h0);
        pkt = 1;
        cyc(1);
        pkt = 0;
        cyc(1);
        rd(PMLS_OFF_WAKE, 32'h21000000);
        // system reset must leave pending wake causes alone
        rstn = 0;
        cyc(2);
        `CHK(fc_cmd, PMLS_FC_OFF)
        `CHK(pme_st, 1'b1)
        rstn = 1;
        cyc(2);
        rd(PMLS_OFF_WAKE, 32'h21000000);
        alt_n = 0;
        cyc(2);
        alt_n = 1;
        cyc(1);
        rd(PMLS_OFF_WAKE, 32'h0);
        pme_en = 0;
        wev = 1;
        cyc(1);
        wev = 0;
        cyc(1);
        rd(PMLS_OFF_WAKE, 32'h01000000);
        `CHK(pme_as, 1'b0)
        // set wins over a write-one clear in the same cycle
        req <= '{1'b1, 1'b1, PMLS_OFF_WAKE, 4'h8, 32'h01000000};
        wev = 1;
        cyc(1);
        req <= '0;
        wev = 0;
        cyc(1);
        `CHK(pme_st, 1'b1)
        pclr = 1;
        cyc(1);
        pclr = 0;
        cyc(1);
        `CHK(pme_st, 1'b0)
        phy = '{1'b0, 1'b1, 1'b1};
        pstate = PMLS_D3;
        wr(PMLS_OFF_GEN, 4'h1, 32'h3);
        cyc(1);
        rd(PMLS_OFF_GEN, 32'h0603);
        `CHK(clkreq, 1'b1)
        `CHK(dpd, 1'b1)
        pstate = 2'h0;
        cyc(2);
        `CHK(dpd, 1'b0)
        phy = '{1'b1, 1'b0, 1'b0};
        wr(PMLS_OFF_GEN, 4'h2, 32'hFF00);
        rd(PMLS_OFF_GEN, 32'h0103);
        rd(PMLS_OFF_GEN, 32'h0103);
        results;
    end
endmodule
